// [src/scdr_pkg.sv]
// Shared constants and carrier types for the serial link monitor
package scdr_pkg;

   // ********************************************************************
   // Rate and reference figures
   // ********************************************************************
   localparam int REF_MULT = 8;
   localparam int REF_HI_KHZ = 19440;
   localparam int REF_LO_KHZ = 6480;
   localparam int BIT_HI_KHZ = REF_HI_KHZ * REF_MULT;
   localparam int BIT_LO_KHZ = REF_LO_KHZ * REF_MULT;
   localparam int LOCK_TOL_PPM = 1000;

   // ********************************************************************
   // Quiet-line detector counts
   // ********************************************************************
   localparam int QUIET_BITS = 512;
   localparam int RECOVER_EDGES = 64;
   localparam int WIN_W = 10;
   localparam logic [WIN_W-1:0] WIN_RST = 10'h000;
   localparam logic [WIN_W-1:0] QUIET_LAST = 10'h1ff;
   localparam logic [WIN_W-1:0] EDGE_NEED = 10'h040;

   // Frequency check over one window of recovered bits, in reference cycles
   localparam int FREQ_WIN_BITS = 512;
   localparam int FREQ_REF_CYC = FREQ_WIN_BITS / REF_MULT;
   localparam int FREQ_TOL_CYC = 1;

   // ********************************************************************
   // Encodings
   // ********************************************************************
   typedef enum logic [1:0] {
      SCDR_RATE_LO = 2'h0,
      SCDR_RATE_HI = 2'h1,
      SCDR_RATE_TEST = 2'h2
   } scdr_rate_t;

   typedef enum logic [2:0] {
      SCDR_ST_TRACK = 3'h1,
      SCDR_ST_QUIET = 3'h2,
      SCDR_ST_NOCAR = 3'h4
   } scdr_state_t;

   // Power-down straps sampled from the output pairs
   typedef struct packed {
      logic tx_buf_off;
      logic rx_buf_off;
      logic tx_pll_off;
      logic rclk_off;
      logic rdata_off;
   } scdr_pwr_t;

   // Carrier input decoded into its two low levels
   typedef struct packed {
      logic ecl_low;
      logic ttl_low;
   } scdr_car_t;

endpackage

// [src/scdr_skid.sv]
// Two-entry buffer with valid and ready on both sides
module scdr_skid #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);

   // ********************************************************************
   // Storage
   // ********************************************************************
   logic [W-1:0] mem_q [2];
   logic wr_q;
   logic rd_q;
   logic [1:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // Ready is decoded from the registered count alone so it never loops through the sink
   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[rd_q];

   // Pointers and fill count
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cnt_q <= 2'h0;
         mem_q[0] <= '0;
         mem_q[1] <= '0;
      end else begin
         if (push) begin
            mem_q[wr_q] <= in_data;
            wr_q <= ~wr_q;
         end
         if (pop) begin
            rd_q <= ~rd_q;
         end
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   // A full buffer with a stalled sink keeps both words untouched
   a_skid_no_overflow: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (cnt_q == 2'h2 && !out_ready) |=> (cnt_q == 2'h2) && $stable(out_data))
      else $error("full buffer lost or changed a word");

endmodule

// [src/scdr_link_monitor.sv]
// Digital core of the serial clock-and-data-recovery link monitor
// The analog loop is modelled as a bit strobe: rec_bit_tick marks one
// recovered bit period in clk_sys time, ref_tick one reference period.
module scdr_link_monitor (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic rate_sel_hi,
   input wire logic rate_sel_lo,
   input wire logic ref_tick,
   input wire logic transmit_serial_in,
   input wire logic line_serial_in,
   input wire logic wrap_sel,
   input wire logic car_ecl_low,
   input wire logic car_ttl_low,
   input wire logic rec_bit_tick,
   input wire logic tx_out_strap,
   input wire logic rx_out_strap,
   input wire logic transmit_bit_clock_strap,
   input wire logic rclk_strap,
   input wire logic rdata_strap,
   input wire logic rx_ready,
   output logic buffered_line_out,
   output logic receive_buffer_out,
   output logic recovered_data_out,
   output logic recovered_data_valid,
   output logic recovered_clock_out,
   output logic transmit_bit_clock,
   output logic link_fault_n,
   output logic pll_unlocked,
   output logic [1:0] rate_mode,
   output logic test_mode
);

   // ********************************************************************
   // Input synchronisers, two flops each
   // ********************************************************************
   localparam int NSYNC = 15;
   logic [NSYNC-1:0] s1_q;
   logic [NSYNC-1:0] s2_q;
   wire [NSYNC-1:0] raw_in = {rate_sel_hi, rate_sel_lo, ref_tick, transmit_serial_in,
      line_serial_in, wrap_sel, car_ecl_low, car_ttl_low, rec_bit_tick, tx_out_strap,
      rx_out_strap, transmit_bit_clock_strap, rclk_strap, rdata_strap, 1'b0};

   // Only the second stage is read by logic
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= raw_in;
         s2_q <= s1_q;
      end
   end

   wire r_hi = s2_q[14];
   wire r_lo = s2_q[13];
   wire r_ref = s2_q[12];
   wire r_tx = s2_q[11];
   wire r_line = s2_q[10];
   wire r_wrap = s2_q[9];
   scdr_pkg::scdr_car_t car;
   assign car = {s2_q[8], s2_q[7]};
   wire r_bit = s2_q[6];
   scdr_pkg::scdr_pwr_t pwr;
   assign pwr = {s2_q[5], s2_q[4], s2_q[3], s2_q[2], s2_q[1]};

   // ********************************************************************
   // Rate decode: both level comparators false means mid-level
   // ********************************************************************
   scdr_pkg::scdr_rate_t rate_d;
   assign rate_d = r_hi ? scdr_pkg::SCDR_RATE_HI :
      (r_lo ? scdr_pkg::SCDR_RATE_LO : scdr_pkg::SCDR_RATE_TEST);

   // ********************************************************************
   // Path select and power-down decode
   // ********************************************************************
   // Unconnected carrier reads as TTL low, so detector off is the default
   wire det_off = car.ttl_low;
   wire car_lost = car.ecl_low && !car.ttl_low;
   wire rx_pll_off = pwr.rclk_off && pwr.rdata_off;
   wire sel_data = r_wrap ? r_line : r_tx;
   wire bit_strobe = r_bit && !rx_pll_off;

   // ********************************************************************
   // Transition window, restarted every 512 bit times
   // ********************************************************************
   logic prev_q;
   logic [scdr_pkg::WIN_W-1:0] quiet_q;
   logic [scdr_pkg::WIN_W-1:0] win_q;
   logic [scdr_pkg::WIN_W-1:0] edges_q;
   wire edge_seen = bit_strobe && (sel_data != prev_q);
   wire win_end = bit_strobe && (win_q == scdr_pkg::QUIET_LAST);
   wire quiet_hit = bit_strobe && !edge_seen && (quiet_q == scdr_pkg::QUIET_LAST);
   wire edges_ok = (edges_q + {9'h000, edge_seen}) >= scdr_pkg::EDGE_NEED;

   // Bit-time counters advance only on recovered-clock strobes
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         prev_q <= 1'b0;
         quiet_q <= scdr_pkg::WIN_RST;
         win_q <= scdr_pkg::WIN_RST;
         edges_q <= scdr_pkg::WIN_RST;
      end else if (bit_strobe) begin
         prev_q <= sel_data;
         quiet_q <= edge_seen ? scdr_pkg::WIN_RST : quiet_q + 10'h001;
         win_q <= win_end ? scdr_pkg::WIN_RST : win_q + 10'h001;
         edges_q <= win_end ? scdr_pkg::WIN_RST :
            (edges_q + {9'h000, edge_seen});
      end
   end

   // ********************************************************************
   // Lock check: reference cycles per 512 recovered bits
   // ********************************************************************
   logic ref_prev_q;
   logic [7:0] ref_cnt_q;
   logic [scdr_pkg::WIN_W-1:0] fwin_q;
   logic ool_q;
   wire ref_rise = r_ref && !ref_prev_q;
   wire fwin_end = bit_strobe && (fwin_q == scdr_pkg::QUIET_LAST);
   wire [7:0] ref_lo_lim = 8'(scdr_pkg::FREQ_REF_CYC - scdr_pkg::FREQ_TOL_CYC);
   wire [7:0] ref_hi_lim = 8'(scdr_pkg::FREQ_REF_CYC + scdr_pkg::FREQ_TOL_CYC);
   // Coarse: one reference cycle in 64 is far wider than 1000 ppm
   wire ool_d = (ref_cnt_q < ref_lo_lim) || (ref_cnt_q > ref_hi_lim);

   // Out-of-lock judged once per window, held until the next
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ref_prev_q <= 1'b0;
         ref_cnt_q <= 8'h00;
         fwin_q <= scdr_pkg::WIN_RST;
         ool_q <= 1'b0;
      end else begin
         ref_prev_q <= r_ref;
         if (fwin_end) begin
            ref_cnt_q <= {7'h00, ref_rise};
            ool_q <= ool_d;
         end else if (ref_rise && ref_cnt_q != 8'hff) begin
            ref_cnt_q <= ref_cnt_q + 8'h01;
         end
         if (bit_strobe) begin
            fwin_q <= fwin_end ? scdr_pkg::WIN_RST : fwin_q + 10'h001;
         end
      end
   end

   // ********************************************************************
   // Link state machine
   // ********************************************************************
   scdr_pkg::scdr_state_t st_q;
   scdr_pkg::scdr_state_t st_d;
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         scdr_pkg::SCDR_ST_TRACK: begin
            if (car_lost) begin
               st_d = scdr_pkg::SCDR_ST_NOCAR;
            end else if (!det_off && quiet_hit) begin
               st_d = scdr_pkg::SCDR_ST_QUIET;
            end
         end
         scdr_pkg::SCDR_ST_QUIET: begin
            if (car_lost) begin
               st_d = scdr_pkg::SCDR_ST_NOCAR;
            end else if (det_off || (win_end && edges_ok)) begin
               st_d = scdr_pkg::SCDR_ST_TRACK;
            end
         end
         scdr_pkg::SCDR_ST_NOCAR: begin
            if (!car_lost) begin
               st_d = scdr_pkg::SCDR_ST_QUIET;
            end
         end
         default: st_d = scdr_pkg::SCDR_ST_NOCAR;
      endcase
      if (det_off && !car_lost) begin
         st_d = scdr_pkg::SCDR_ST_TRACK;
      end
   end

   // Fault is low in a lost state, or out-of-lock with detector off
   wire fault_d = (st_d != scdr_pkg::SCDR_ST_TRACK) || (det_off && ool_q);
   // Loop held at reference while the line is not trusted
   wire hold_ref = (st_d != scdr_pkg::SCDR_ST_TRACK);
   wire no_car = (st_d == scdr_pkg::SCDR_ST_NOCAR);
   wire rdata_d = no_car ? 1'b0 : sel_data;

   // ********************************************************************
   // Transmit clock: system clock halved, toggled on every clk_sys cycle outside test mode and power-down
   // ********************************************************************
   logic transmit_bit_clock_q;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         transmit_bit_clock_q <= 1'b0;
      end else if (pwr.tx_pll_off || rate_d == scdr_pkg::SCDR_RATE_TEST) begin
         transmit_bit_clock_q <= 1'b0;
      end else begin
         transmit_bit_clock_q <= ~transmit_bit_clock_q;
      end
   end

   // ********************************************************************
   // Recovered data through the two-entry buffer
   // ********************************************************************
   logic sk_valid;
   logic sk_data;
   logic sk_in_ready;
   scdr_skid #(
      .W(1)
   ) u_skid (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .in_data(rdata_d),
      .in_valid(bit_strobe),
      .in_ready(sk_in_ready),
      .out_data(sk_data),
      .out_valid(sk_valid),
      .out_ready(rx_ready)
   );

   // ********************************************************************
   // Output registers
   // ********************************************************************
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= scdr_pkg::SCDR_ST_NOCAR;
         link_fault_n <= 1'b0;
         pll_unlocked <= 1'b0;
         recovered_data_out <= 1'b0;
         recovered_data_valid <= 1'b0;
         recovered_clock_out <= 1'b0;
         buffered_line_out <= 1'b0;
         receive_buffer_out <= 1'b0;
         transmit_bit_clock <= 1'b0;
         rate_mode <= 2'h0;
         test_mode <= 1'b0;
      end else begin
         st_q <= st_d;
         link_fault_n <= !fault_d;
         pll_unlocked <= det_off && ool_q;
         // Gated here too, so a stale buffered word never shows without carrier
         recovered_data_out <= (rx_pll_off || no_car) ? 1'b0 : sk_data;
         recovered_data_valid <= sk_valid && rx_ready && !rx_pll_off;
         recovered_clock_out <= rx_pll_off ? 1'b0 : (hold_ref ? transmit_bit_clock_q : r_bit);
         buffered_line_out <= pwr.tx_buf_off ? 1'b0 : r_tx;
         receive_buffer_out <= pwr.rx_buf_off ? 1'b0 : sel_data;
         transmit_bit_clock <= transmit_bit_clock_q;
         rate_mode <= rate_d;
         test_mode <= (rate_d == scdr_pkg::SCDR_RATE_TEST);
      end
   end

   // ********************************************************************
   // Checks
   // ********************************************************************
   sequence s_car_lost;
      car_lost;
   endsequence

   // Two running cycles in a row must show a toggle on the output pair
   sequence s_tx_run;
      (!pwr.tx_pll_off && rate_d != scdr_pkg::SCDR_RATE_TEST) [*2];
   endsequence

   sequence s_quiet_win;
      st_q == scdr_pkg::SCDR_ST_QUIET && !car_lost && !det_off && win_end && edges_ok;
   endsequence

   a_car_fault: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_car_lost |=> !link_fault_n)
      else $error("carrier loss did not raise fault");
   a_car_data_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_car_lost |=> !recovered_data_out)
      else $error("data not held low without carrier");
   a_quiet_fault: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (!det_off && !car_lost && quiet_hit) |=> !link_fault_n)
      else $error("quiet line did not raise fault");
   a_det_off_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (det_off && !ool_q) |=> link_fault_n)
      else $error("fault without out-of-lock while detector off");
   a_recover_edges: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (st_q == scdr_pkg::SCDR_ST_QUIET && st_d == scdr_pkg::SCDR_ST_TRACK && !det_off)
      |-> edges_ok && win_end)
      else $error("recovery without enough transitions");
   a_quiet_recover: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_quiet_win |=> link_fault_n)
      else $error("enough transitions did not release fault");
   a_wrap_path: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (!r_wrap && !pwr.rx_buf_off) |=> receive_buffer_out == $past(r_tx))
      else $error("wrap low did not pick transmit input");
   a_tx_pll_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
      pwr.tx_pll_off |=> ##1 !transmit_bit_clock)
      else $error("transmit clock runs while powered down");
   a_tx_clk_run: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_tx_run |=> transmit_bit_clock != $past(transmit_bit_clock))
      else $error("transmit clock stuck while enabled");
   a_tx_pass: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !pwr.tx_buf_off |=> buffered_line_out == $past(r_tx))
      else $error("line output does not follow transmit input");
   a_tx_buf_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
      pwr.tx_buf_off |=> !buffered_line_out)
      else $error("transmit buffer active while strapped off");
   a_rx_buf_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
      pwr.rx_buf_off |=> !receive_buffer_out)
      else $error("receive buffer active while strapped off");
   a_rx_pll_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
      rx_pll_off |=> !recovered_clock_out && !recovered_data_out)
      else $error("receive outputs active while powered down");
   a_rclk_track: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (!hold_ref && !rx_pll_off) |=> recovered_clock_out == $past(r_bit))
      else $error("recovered clock does not follow bit strobe");
   a_rclk_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (hold_ref && !rx_pll_off) |=> recovered_clock_out == $past(transmit_bit_clock_q))
      else $error("recovered clock not held to reference");
   a_rate_hi: assert property (@(posedge clk_sys) disable iff (!arst_n)
      r_hi |=> rate_mode == scdr_pkg::SCDR_RATE_HI)
      else $error("high rate select missed upper range");
   a_rate_lo: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (!r_hi && r_lo) |=> rate_mode == scdr_pkg::SCDR_RATE_LO)
      else $error("low rate select missed lower range");
   a_test_mode: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (!r_hi && !r_lo) |=> test_mode)
      else $error("mid-level rate select missed test mode");

endmodule

// [tb/scdr_sink_model.sv]
// Behavioural model of the downstream serial-to-parallel sink
module scdr_sink_model (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic slow,
   input wire logic hold,
   output logic rx_ready
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [1:0] ph_q;

   // Slow mode drops ready one cycle in four; hold stalls outright
   // Non-blocking on the rising edge: the design samples the old value,
   // and the bench's falling-edge controls are never raced
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ph_q <= 2'h0;
         rx_ready <= 1'b0;
      end else begin
         ph_q <= ph_q + 2'h1;
         rx_ready <= !hold && !(slow && ph_q == 2'h0);
      end
   end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the serial link monitor
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("wrong value at %0t: got %h exp %h", $time, got, exp); end end

module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   // ********************************************************************
   // Signals
   // ********************************************************************
   logic clk_sys = 1'b0, arst_n = 1'b0, rate_sel_hi = 1'b1, rate_sel_lo = 1'b0;
   logic ref_tick = 1'b0, transmit_serial_in = 1'b0, line_serial_in = 1'b0;
   logic wrap_sel = 1'b1, car_ecl_low = 1'b0, car_ttl_low = 1'b0, rec_bit_tick = 1'b0;
   logic tx_out_strap = 1'b0, rx_out_strap = 1'b0, transmit_bit_clock_strap = 1'b0;
   logic rclk_strap = 1'b0, rdata_strap = 1'b0, rx_ready, slow = 1'b1, hold = 1'b0;
   logic buffered_line_out, receive_buffer_out, recovered_data_out, recovered_data_valid;
   logic recovered_clock_out, transmit_bit_clock, link_fault_n, pll_unlocked, test_mode;
   logic [1:0] rate_mode;
   logic [31:0] rnd = 32'ha470;
   logic chk_on = 1'b0, t0, t1, exp_bit;
   logic exp_q[$];
   int n_errors = 0, n_checks = 0, n_words = 0, ref_div = 4, ref_ph = 0, w0;

   scdr_link_monitor dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .rate_sel_hi(rate_sel_hi),
      .rate_sel_lo(rate_sel_lo), .ref_tick(ref_tick), .transmit_serial_in(transmit_serial_in),
      .line_serial_in(line_serial_in), .wrap_sel(wrap_sel), .car_ecl_low(car_ecl_low),
      .car_ttl_low(car_ttl_low), .rec_bit_tick(rec_bit_tick), .tx_out_strap(tx_out_strap),
      .rx_out_strap(rx_out_strap), .transmit_bit_clock_strap(transmit_bit_clock_strap), .rclk_strap(rclk_strap),
      .rdata_strap(rdata_strap), .rx_ready(rx_ready), .buffered_line_out(buffered_line_out),
      .receive_buffer_out(receive_buffer_out), .recovered_data_out(recovered_data_out),
      .recovered_data_valid(recovered_data_valid), .recovered_clock_out(recovered_clock_out),
      .transmit_bit_clock(transmit_bit_clock), .link_fault_n(link_fault_n),
      .pll_unlocked(pll_unlocked), .rate_mode(rate_mode), .test_mode(test_mode));

   scdr_sink_model sink_u (.clk_sys(clk_sys), .arst_n(arst_n), .slow(slow), .hold(hold),
      .rx_ready(rx_ready));

   // 10 MHz system clock
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   // ********************************************************************
   // Helpers
   // ********************************************************************
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // One recovered bit: two cycles, strobe high in the first; the other
   // input carries noise so a wrong source choice shows up
   task automatic send_bit(input logic b, input logic keep);
      @(negedge clk_sys);
      rnd = lfsr_next(rnd);
      line_serial_in = wrap_sel ? b : rnd[0];
      transmit_serial_in = wrap_sel ? rnd[0] : b;
      rec_bit_tick = 1'b1;
      ref_ph++;
      // Reference held at one eighth of the bit rate unless a test skews it
      if (ref_ph >= ref_div) begin
         ref_ph = 0;
         ref_tick = ~ref_tick;
      end
      if (chk_on && keep) exp_q.push_back(b);
      @(negedge clk_sys);
      rec_bit_tick = 1'b0;
   endtask

   // Bits with a transition every `gap` bits
   task automatic send_run(input int n, input int gap);
      logic v;
      v = 1'b0;
      for (int i = 0; i < n; i++) begin
         if (gap > 0 && i % gap == 0) v = ~v;
         send_bit(v, 1'b1);
      end
   endtask

   // Bounded wait for the fault level; running out counts a mismatch
   task automatic wait_fault(input logic v, input int lim);
      int i;
      for (i = 0; i < lim && link_fault_n !== v; i++) @(negedge clk_sys);
      `CHK(link_fault_n, v)
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Output watcher: while checking is on, every word taken is matched to the oldest note
   always @(negedge clk_sys) begin
      if (recovered_data_valid === 1'b1) begin
         n_words++;
         if (chk_on) begin
            exp_bit = (exp_q.size() > 0) ? exp_q.pop_front() : ~recovered_data_out;
            `CHK(recovered_data_out, exp_bit)
         end
      end
   end

   // ********************************************************************
   // Main sequence
   // ********************************************************************
   initial begin
      idle(2);
      arst_n = 1'b1;
      idle(5);
      // Rate pin: upper, lower, floating
      for (int i = 0; i < 3; i++) begin
         {rate_sel_hi, rate_sel_lo} = (i == 0) ? 2'b10 : (i == 1) ? 2'b01 : 2'b00;
         idle(5);
         `CHK(rate_mode, (i == 0) ? 2'h1 : (i == 1) ? 2'h0 : 2'h2)
         `CHK(test_mode, (i == 2))
      end
      rate_sel_hi = 1'b1;
      rate_sel_lo = 1'b0;
      $display("done rate select");
      // Transmit pass-through and wrapped receive buffer, then both strapped off
      wrap_sel = 1'b0;
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr_next(rnd);
         transmit_serial_in = rnd[0];
         idle(5);
         `CHK(buffered_line_out, rnd[0])
         `CHK(receive_buffer_out, rnd[0])
      end
      tx_out_strap = 1'b1;
      rx_out_strap = 1'b1;
      transmit_serial_in = 1'b1;
      idle(5);
      `CHK(buffered_line_out, 1'b0)
      `CHK(receive_buffer_out, 1'b0)
      tx_out_strap = 1'b0;
      rx_out_strap = 1'b0;
      wrap_sel = 1'b1;
      idle(5);
      `CHK(receive_buffer_out, line_serial_in)
      // Transmit clock runs, then stops when its pair is strapped
      t0 = transmit_bit_clock;
      idle(1);
      `CHK(transmit_bit_clock, ~t0)
      transmit_bit_clock_strap = 1'b1;
      idle(5);
      t0 = transmit_bit_clock;
      idle(1);
      `CHK(transmit_bit_clock, t0)
      transmit_bit_clock_strap = 1'b0;
      $display("done transmit side");
      // Carrier held high while data is valid; warm the link up
      car_ecl_low = 1'b0;
      send_run(1100, 1);
      wait_fault(1'b1, 20);
      idle(10);
      chk_on = 1'b1;
      // Random data from the line, then looped from the transmit input
      for (int i = 0; i < 128; i++) begin
         wrap_sel = (i < 64);
         rnd = lfsr_next(rnd);
         send_bit(rnd[5], 1'b1);
      end
      wrap_sel = 1'b1;
      idle(20);
      $display("done data paths");
      // Sink stalls: two words fit, a third is lost
      hold = 1'b1;
      idle(4);
      send_bit(1'b1, 1'b1);
      send_bit(1'b0, 1'b1);
      send_bit(1'b1, 1'b0);
      idle(4);
      hold = 1'b0;
      idle(20);
      `CHK(exp_q.size(), 0)
      chk_on = 1'b0;
      $display("done buffer stall");
      // Receive loop off: no words, fault still follows carrier
      rclk_strap = 1'b1;
      rdata_strap = 1'b1;
      idle(5);
      w0 = n_words;
      send_run(16, 1);
      idle(10);
      `CHK(n_words, w0)
      `CHK(recovered_data_out, 1'b0)
      car_ecl_low = 1'b1;
      wait_fault(1'b0, 10);
      rclk_strap = 1'b0;
      rdata_strap = 1'b0;
      $display("done receive power down");
      // No carrier: fault low, data held low while the line sits high
      wait_fault(1'b0, 10);
      for (int i = 0; i < 16; i++) begin
         send_bit(1'b1, 1'b0);
         `CHK(recovered_data_out, 1'b0)
      end
      car_ecl_low = 1'b0;
      send_run(1100, 1);
      wait_fault(1'b1, 20);
      $display("done carrier loss");
      // Quiet line: 511 edge-free bits still fine, the 512th faults
      send_bit(1'b1, 1'b0);
      for (int i = 0; i < 511; i++) send_bit(1'b1, 1'b0);
      idle(6);
      `CHK(link_fault_n, 1'b1)
      `CHK(recovered_clock_out, 1'b0)
      send_bit(1'b1, 1'b0);
      wait_fault(1'b0, 10);
      // Loop now runs from the reference, not from the idle line
      t0 = recovered_clock_out;
      idle(1);
      `CHK(recovered_clock_out, ~t0)
      // Too few transitions in any window keeps the fault
      send_run(1100, 18);
      idle(6);
      `CHK(link_fault_n, 1'b0)
      send_run(1100, 1);
      wait_fault(1'b1, 20);
      $display("done quiet line");
      // Detector off: quiet line ignored, only lock loss faults
      car_ttl_low = 1'b1;
      send_run(600, 0);
      idle(6);
      `CHK(link_fault_n, 1'b1)
      `CHK(pll_unlocked, 1'b0)
      ref_div = 2;
      send_run(1100, 0);
      wait_fault(1'b0, 20);
      `CHK(pll_unlocked, 1'b1)
      ref_div = 4;
      send_run(1100, 0);
      wait_fault(1'b1, 20);
      car_ttl_low = 1'b0;
      $display("done lock monitor");
      wrap_up();
   end
endmodule
